/* hdl/bod_consts.svh */
// Purpose: Offsets, field positions, codes and reset values of the blit decode block
// Assumes: Register index times four gives the Avalon byte address
// Notes:   Definitions only
//
// Overview of operation
// - 0000 write blit with ROP; 0001 read blit
// - 0010/0011 move blit with ROP, positive/negative
// - 0100 transparent write; 0101 transparent positive move
// - 0110 pattern fill ROP; 0111 pattern fill transparent
// - 1000-1011 colour expansion variants; 1100 solid fill
// - ROP code picks boolean combine of S, D
// - Pattern fill uses same functions with P
// - Colour expansion: ROP code is start bit
// - 8 bpp pattern address split [20:6]/[5:3]/[2:0]
// - 16 bpp pattern address split [20:7]/[6:4]/[3:0]
// - Write one starts; active bit reads busy
`ifndef BOD_CONSTS_SVH
`define BOD_CONSTS_SVH
// Register indices; byte address is index times four
`define BOD_IDX_ACTIVE   9'h100
`define BOD_IDX_ROP      9'h102
`define BOD_IDX_OPSEL    9'h103
`define BOD_IDX_SRC      9'h104
`define BOD_IDX_PATCFG   9'h107
`define BOD_IDX_STATUS   9'h108
// Field positions
`define BOD_ACTIVE_BIT   0
`define BOD_PAT16_BIT    0
// Reset values
`define BOD_RST_ROP      4'h0
`define BOD_RST_OPSEL    4'h0
`define BOD_RST_SRC      24'h000000
// Operation select codes
`define BOD_OPC_WRITE_ROP  4'h0
`define BOD_OPC_READ       4'h1
`define BOD_OPC_MOVE_POS   4'h2
`define BOD_OPC_MOVE_NEG   4'h3
`define BOD_OPC_TWRITE     4'h4
`define BOD_OPC_TMOVE_POS  4'h5
`define BOD_OPC_PAT_ROP    4'h6
`define BOD_OPC_PAT_TRANS  4'h7
`define BOD_OPC_CEXP       4'h8
`define BOD_OPC_CEXP_TRANS 4'h9
`define BOD_OPC_MCEXP      4'ha
`define BOD_OPC_MCEXP_TR   4'hb
`define BOD_OPC_SOLID      4'hc
`endif

/* hdl/bod_pkg.sv */
// Purpose: Types shared by the blit decode block
// Assumes: Codes live in bod_consts.svh
// Notes:   No constants here, only types
package bod_pkg;
	// Decoded blit operation
	typedef enum logic [3:0] {
		BOD_OP_WRITE_ROP, BOD_OP_READ, BOD_OP_MOVE_POS, BOD_OP_MOVE_NEG,
		BOD_OP_TWRITE, BOD_OP_TMOVE_POS, BOD_OP_PAT_ROP, BOD_OP_PAT_TRANS,
		BOD_OP_CEXP, BOD_OP_CEXP_TRANS, BOD_OP_MCEXP, BOD_OP_MCEXP_TR,
		BOD_OP_SOLID, BOD_OP_RSVD
	} bod_op_t;

	// Sequencer state
	typedef enum logic [1:0] {
		BOD_ST_IDLE, BOD_ST_PUSH, BOD_ST_RUN
	} bod_state_t;

	// Command descriptor handed to the datapath
	typedef struct packed {
		bod_op_t     op;          // Decoded operation
		logic        neg_dir;     // Walk memory downward
		logic        transparent; // Transparency applies
		logic        use_rop;     // Boolean combine applies
		logic        use_pat;     // Pattern replaces source
		logic        cexp;        // Colour expansion
		logic [3:0]  rop;         // Combine truth table
		logic [3:0]  start_bit;   // Expansion start bit
		logic [20:0] pat_base;    // Pattern base address
		logic [2:0]  pat_line;    // Pattern line offset
		logic [3:0]  pat_pixel;   // Pixel offset
		logic [23:0] src_addr;    // Raw source start address
	} bod_desc_t;
endpackage

/* hdl/bod_blit_decode.sv */
// Purpose: Blit operation decode with Avalon-MM registers and a command FIFO
// Assumes: All inputs synchronous to core_clk; rst synchronous, active high
// Notes:   The datapath drains descriptors and pulses op_done when finished
`timescale 1ns/100ps
`include "bod_consts.svh"

// Command FIFO; out_data comes straight from the storage flops
module bod_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk,  // Core clock
	input  wire logic             rst,       // Synchronous reset
	input  wire logic             in_valid,  // Writer offers a word
	output logic                  in_ready,  // Room for a word
	input  wire logic [WIDTH-1:0] in_data,   // Word in
	output logic                  out_valid, // Word available
	input  wire logic             out_ready, // Reader takes word
	output logic      [WIDTH-1:0] out_data   // Oldest word
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];  // Storage
	logic [AW-1:0]    wr_ptr;       // Next slot written
	logic [AW-1:0]    rd_ptr;       // Next slot read
	logic [AW:0]      count;        // Words held
	logic             push;         // Write this cycle
	logic             pop;          // Read this cycle

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr];

	// Storage write; no reset needed on data
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// Top: register file, decode, sequencer and pixel combine
module bod_blit_decode #(
	parameter int DW    = 16, // Pixel word width of combine unit
	parameter int DEPTH = 8   // Command FIFO depth
) (
	input  wire logic             core_clk,        // Core clock, 250 MHz
	input  wire logic             rst,             // Synchronous reset
	input  wire logic [10:0]      avs_address,     // Byte address
	input  wire logic             avs_read,        // Read request
	input  wire logic             avs_write,       // Write request
	input  wire logic [31:0]      avs_writedata,   // Write data
	input  wire logic [3:0]       avs_byteenable,  // Byte lanes
	output logic      [31:0]      avs_readdata,    // Read data
	output logic                  avs_waitrequest, // Stall
	output logic                  cmd_valid,       // Descriptor ready
	input  wire logic             cmd_ready,       // Datapath takes it
	output bod_pkg::bod_desc_t    cmd_desc,        // Descriptor
	input  wire logic             op_done,         // Datapath finished
	input  wire logic [DW-1:0]    comb_src,        // Source or pattern word
	input  wire logic [DW-1:0]    comb_dst,        // Destination word
	output logic      [DW-1:0]    comb_out         // Combined word
);
	localparam int DESC_W = $bits(bod_pkg::bod_desc_t);

	logic               ack;        // Bus answer phase
	logic               req;        // Bus request present
	logic [8:0]         idx;        // Register index
	logic               wr_now;     // Write takes effect
	logic [3:0]         rop;        // Raster operation code
	logic [3:0]         opsel;      // Operation select
	logic [23:0]        src_addr;   // Source start address
	logic               pat16;      // Pattern at 16 bpp
	logic               last_rsvd;  // Last start was refused
	logic               go;         // Start request accepted
	bod_pkg::bod_state_t state;     // Sequencer state
	bod_pkg::bod_desc_t next_desc;  // Descriptor being built
	bod_pkg::bod_desc_t desc_q;     // Descriptor held for push
	logic               fifo_ready; // FIFO has room
	logic               active;     // Busy as seen by software
	logic [31:0]        next_rdata; // Read mux
	wire  [DW-1:0]      comb_bit;   // Combine result ahead of the output flop

	assign req             = avs_read | avs_write;
	assign idx             = avs_address[10:2];
	assign avs_waitrequest = req & ~ack;
	assign wr_now          = avs_write & ack;
	assign active          = (state != bod_pkg::BOD_ST_IDLE);
	assign go = wr_now & (idx == `BOD_IDX_ACTIVE) & avs_byteenable[0]
		& avs_writedata[`BOD_ACTIVE_BIT] & ~active;

	// Answer every request after one wait cycle, unmapped included
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	// Control registers; lane 0 holds the 4-bit and 1-bit ones
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rop      <= `BOD_RST_ROP;
			opsel    <= `BOD_RST_OPSEL;
			src_addr <= `BOD_RST_SRC;
			pat16    <= 1'b0;
		end else if (wr_now) begin
			case (idx)
				`BOD_IDX_ROP: begin
					if (avs_byteenable[0]) rop <= avs_writedata[3:0];
				end
				`BOD_IDX_OPSEL: begin
					if (avs_byteenable[0]) opsel <= avs_writedata[3:0];
				end
				`BOD_IDX_SRC: begin
					if (avs_byteenable[0]) src_addr[7:0]   <= avs_writedata[7:0];
					if (avs_byteenable[1]) src_addr[15:8]  <= avs_writedata[15:8];
					if (avs_byteenable[2]) src_addr[23:16] <= avs_writedata[23:16];
				end
				`BOD_IDX_PATCFG: begin
					if (avs_byteenable[0]) pat16 <= avs_writedata[`BOD_PAT16_BIT];
				end
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end
	end

	// Read mux; narrow registers read zero above their width
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (idx)
			`BOD_IDX_ACTIVE: next_rdata[`BOD_ACTIVE_BIT] = active;
			`BOD_IDX_ROP:    next_rdata[3:0] = rop;
			`BOD_IDX_OPSEL:  next_rdata[3:0] = opsel;
			`BOD_IDX_SRC:    next_rdata[23:0] = src_addr;
			`BOD_IDX_PATCFG: next_rdata[`BOD_PAT16_BIT] = pat16;
			`BOD_IDX_STATUS: next_rdata[5:0] = {~fifo_ready, last_rsvd, desc_q.op};
			default:         next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data registered so it stands with waitrequest low
	always_ff @(posedge core_clk) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~ack) begin
			avs_readdata <= next_rdata;
		end
	end

	// Operation decode and address split
	always_comb begin
		next_desc          = '0;
		next_desc.rop      = rop;
		next_desc.src_addr = src_addr;
		case (opsel)
			`BOD_OPC_WRITE_ROP: begin next_desc.op = bod_pkg::BOD_OP_WRITE_ROP;
				next_desc.use_rop = 1'b1; end
			`BOD_OPC_READ:      next_desc.op = bod_pkg::BOD_OP_READ;
			`BOD_OPC_MOVE_POS:  begin next_desc.op = bod_pkg::BOD_OP_MOVE_POS;
				next_desc.use_rop = 1'b1; end
			`BOD_OPC_MOVE_NEG:  begin next_desc.op = bod_pkg::BOD_OP_MOVE_NEG;
				next_desc.use_rop = 1'b1;
				next_desc.neg_dir = 1'b1; end
			`BOD_OPC_TWRITE:    begin next_desc.op = bod_pkg::BOD_OP_TWRITE;
				next_desc.transparent = 1'b1; end
			`BOD_OPC_TMOVE_POS: begin next_desc.op = bod_pkg::BOD_OP_TMOVE_POS;
				next_desc.transparent = 1'b1; end
			`BOD_OPC_PAT_ROP:   begin next_desc.op = bod_pkg::BOD_OP_PAT_ROP;
				next_desc.use_rop = 1'b1;
				next_desc.use_pat = 1'b1; end
			`BOD_OPC_PAT_TRANS: begin next_desc.op = bod_pkg::BOD_OP_PAT_TRANS;
				next_desc.use_pat = 1'b1;
				next_desc.transparent = 1'b1; end
			`BOD_OPC_CEXP:      begin next_desc.op = bod_pkg::BOD_OP_CEXP;
				next_desc.cexp = 1'b1; end
			`BOD_OPC_CEXP_TRANS: begin next_desc.op = bod_pkg::BOD_OP_CEXP_TRANS;
				next_desc.cexp = 1'b1;
				next_desc.transparent = 1'b1; end
			`BOD_OPC_MCEXP:     begin next_desc.op = bod_pkg::BOD_OP_MCEXP;
				next_desc.cexp = 1'b1; end
			`BOD_OPC_MCEXP_TR:  begin next_desc.op = bod_pkg::BOD_OP_MCEXP_TR;
				next_desc.cexp = 1'b1;
				next_desc.transparent = 1'b1; end
			`BOD_OPC_SOLID:     next_desc.op = bod_pkg::BOD_OP_SOLID;
			default:            next_desc.op = bod_pkg::BOD_OP_RSVD;
		endcase
		// Expansion reuses the ROP field as a bit index
		if (next_desc.cexp) begin
			next_desc.start_bit = rop;
		end
		// Pattern base is aligned to the pattern size
		if (pat16) begin
			next_desc.pat_base  = {src_addr[20:7], 7'h00};
			next_desc.pat_line  = src_addr[6:4];
			next_desc.pat_pixel = src_addr[3:0];
		end else begin
			next_desc.pat_base  = {src_addr[20:6], 6'h00};
			next_desc.pat_line  = src_addr[5:3];
			next_desc.pat_pixel = {1'b0, src_addr[2:0]};
		end
	end

	// Sequencer: reserved codes never leave idle, so memory is untouched
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= bod_pkg::BOD_ST_IDLE;
		end else begin
			case (state)
				bod_pkg::BOD_ST_IDLE: begin
					if (go && next_desc.op != bod_pkg::BOD_OP_RSVD) begin
						state <= bod_pkg::BOD_ST_PUSH;
					end
				end
				bod_pkg::BOD_ST_PUSH: begin
					// Full FIFO stalls the start here
					if (fifo_ready) state <= bod_pkg::BOD_ST_RUN;
				end
				bod_pkg::BOD_ST_RUN: begin
					if (op_done) state <= bod_pkg::BOD_ST_IDLE;
				end
				default: state <= bod_pkg::BOD_ST_IDLE;
			endcase
		end
	end

	// Capture descriptor and refusal flag at each start write accepted while idle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			desc_q    <= '0;
			last_rsvd <= 1'b0;
		end else if (go) begin
			desc_q    <= next_desc;
			last_rsvd <= (next_desc.op == bod_pkg::BOD_OP_RSVD);
		end
	end

	// Descriptor queue toward the datapath
	bod_fifo #(
		.WIDTH (DESC_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (state == bod_pkg::BOD_ST_PUSH),
		.in_ready  (fifo_ready),
		.in_data   (desc_q),
		.out_valid (cmd_valid),
		.out_ready (cmd_ready),
		.out_data  (cmd_desc)
	);

	// Per-bit combine: code bit {S,D} is the result
	generate
		for (genvar i = 0; i < DW; i++) begin : g_comb
			assign comb_bit[i] = rop[{comb_src[i], comb_dst[i]}];
		end
	endgenerate

	// One flop process for the whole word, so no variable has several writers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			comb_out <= '0;
		end else begin
			comb_out <= comb_bit;
		end
	end

	property p_write_rop;
		@(posedge core_clk) disable iff (rst)
		go && opsel == 4'h0 |=> desc_q.op == bod_pkg::BOD_OP_WRITE_ROP && desc_q.use_rop;
	endproperty
	a_write_rop: assert property (p_write_rop) else $error("write blit decode wrong");

	property p_move_neg;
		@(posedge core_clk) disable iff (rst)
		go && opsel == 4'h3 |=> desc_q.neg_dir && desc_q.op == bod_pkg::BOD_OP_MOVE_NEG;
	endproperty
	a_move_neg: assert property (p_move_neg) else $error("negative move decode wrong");

	property p_tmove;
		@(posedge core_clk) disable iff (rst)
		go && opsel == 4'h5 |=> desc_q.transparent && !desc_q.neg_dir;
	endproperty
	a_tmove: assert property (p_tmove) else $error("transparent move decode wrong");

	property p_pat_trans;
		@(posedge core_clk) disable iff (rst)
		go && opsel == 4'h7 |=> desc_q.use_pat && desc_q.transparent && !desc_q.use_rop;
	endproperty
	a_pat_trans: assert property (p_pat_trans) else $error("pattern fill decode wrong");

	property p_solid;
		@(posedge core_clk) disable iff (rst)
		go && opsel == 4'hc |=> desc_q.op == bod_pkg::BOD_OP_SOLID && !desc_q.cexp;
	endproperty
	a_solid: assert property (p_solid) else $error("solid fill decode wrong");

	property p_nor;
		@(posedge core_clk) disable iff (rst)
		rop == 4'h1 && $stable(rop) |=> comb_out == ~($past(comb_src) | $past(comb_dst));
	endproperty
	a_nor: assert property (p_nor) else $error("combine NOR wrong");

	property p_start_bit;
		@(posedge core_clk) disable iff (rst)
		go && opsel == 4'h8 |=> desc_q.start_bit == $past(rop);
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("start bit wrong");

	property p_pat8;
		@(posedge core_clk) disable iff (rst)
		go && !pat16 |=> desc_q.pat_base[5:0] == 6'h00
			&& desc_q.pat_pixel == {1'b0, $past(src_addr[2:0])};
	endproperty
	a_pat8: assert property (p_pat8) else $error("8 bpp split wrong");

	property p_pat16;
		@(posedge core_clk) disable iff (rst)
		go && pat16 |=> desc_q.pat_base[6:0] == 7'h00 && desc_q.pat_line == $past(src_addr[6:4]);
	endproperty
	a_pat16: assert property (p_pat16) else $error("16 bpp split wrong");

	property p_active;
		@(posedge core_clk) disable iff (rst)
		go && next_desc.op != bod_pkg::BOD_OP_RSVD |=> active [*2];
	endproperty
	a_active: assert property (p_active) else $error("active not shown after start");

	property p_rsvd;
		@(posedge core_clk) disable iff (rst)
		go && next_desc.op == bod_pkg::BOD_OP_RSVD |=> !active [*3];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved code started");
endmodule

/* verification/bod_blit_decode_test.sv */
// Purpose: Self-checking bench for the blit operation decode block
// Assumes: Avalon-MM register access with one wait cycle; datapath driven by the bench
// Notes:   Operand words use all four source/destination bit pairs in every check
`timescale 1ns/100ps
`include "bod_consts.svh"

module bod_blit_decode_test;
	logic               core_clk;        // Core clock
	logic               rst;             // Synchronous reset
	logic [10:0]        avs_address;     // Byte address
	logic               avs_read;        // Read request
	logic               avs_write;       // Write request
	logic [31:0]        avs_writedata;   // Write data
	logic [3:0]         avs_byteenable;  // Byte lanes
	logic [31:0]        avs_readdata;    // Read data
	logic               avs_waitrequest; // Stall
	logic               cmd_valid;       // Descriptor ready
	logic               cmd_ready;       // Bench takes descriptor
	bod_pkg::bod_desc_t cmd_desc;        // Descriptor
	logic               op_done;         // Bench ends operation
	logic [15:0]        comb_src;        // Source operand
	logic [15:0]        comb_dst;        // Destination operand
	logic [15:0]        comb_out;        // Combined word
	int                 n_fail;          // Mismatch count
	int                 cmp_count;       // Comparison count

	bod_blit_decode #(.DW(16), .DEPTH(8)) uut (
		.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_desc(cmd_desc), .op_done(op_done), .comb_src(comb_src), .comb_dst(comb_dst),
		.comb_out(comb_out)
	);

	// Free-running core clock, 4 ns period
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// Value comparison; case inequality so unknowns never match
	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One Avalon transfer; an edge passes first so strobes are never set twice in a step
	task automatic bus(input logic wr, input logic [8:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address   <= {idx, 2'b00};
		avs_writedata <= wd;
		avs_read      <= ~wr;
		avs_write     <= wr;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		if (n == 50) begin
			n_fail++;
			$display("mismatch waitrequest expected 0 seen 1");
		end
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Register write, read with compare
	task automatic wr(input logic [8:0] idx, input logic [31:0] d);
		logic [31:0] unused;
		bus(1'b1, idx, d, unused);
	endtask

	task automatic rdc(input logic [8:0] idx, input logic [31:0] exp, input string name);
		logic [31:0] d;
		bus(1'b0, idx, 32'h0, d);
		cmp(name, exp, d);
	endtask

	// Bounded wait for a descriptor; an edge first so a pop just taken has settled
	task automatic wait_cmd();
		int n;
		n = 0;
		@(posedge core_clk);
		while (cmd_valid !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		if (cmd_valid !== 1'b1) begin
			n_fail++;
			$display("mismatch cmd_valid expected 1 seen 0");
		end
	endtask

	// One-cycle pulses on the datapath handshake
	task automatic take_cmd();
		cmd_ready <= 1'b1;
		@(posedge core_clk);
		cmd_ready <= 1'b0;
	endtask

	task automatic end_op();
		op_done <= 1'b1;
		@(posedge core_clk);
		op_done <= 1'b0;
	endtask

	// Truth-table combine: result bit picked by the source and destination pair
	function automatic logic [15:0] comb_exp(input logic [3:0] r, input logic [15:0] s,
		input logic [15:0] d);
		logic [15:0] e;
		for (int i = 0; i < 16; i++) e[i] = r[{s[i], d[i]}];
		return e;
	endfunction

	// Closing verdict; the only place the run ends
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog of 20000 cycles, well above the few hundred cycles the tests need
	initial begin
		#(4 * 20000);
		n_fail++;
		$display("mismatch watchdog expected done seen hang");
		test_done();
	end

	// Main sequence
	initial begin
		logic [31:0] d;
		logic [23:0] s;
		logic [3:0]  r;
		logic [15:0] e6;
		n_fail = 0;
		cmp_count = 0;
		rst = 1'b1;
		avs_address = 11'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		cmd_ready = 1'b0;
		op_done = 1'b0;
		comb_src = 16'h00ff;
		comb_dst = 16'h0f0f;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		// Reset values, unmapped place and source address width
		rdc(`BOD_IDX_ROP, 32'h0, "rop reset");
		rdc(`BOD_IDX_OPSEL, 32'h0, "opsel reset");
		rdc(`BOD_IDX_ACTIVE, 32'h0, "active reset");
		wr(9'h101, 32'hffffffff);
		rdc(9'h101, 32'h0, "unmapped");
		wr(`BOD_IDX_SRC, 32'hffabcdef);
		rdc(`BOD_IDX_SRC, 32'h00abcdef, "src width");
		// Every operation code, reserved ones included
		for (int k = 0; k < 16; k++) begin
			s = 24'(24'h1fcb35 + 24'h00b1d3 * k);
			r = k[3:0] ^ 4'h5;
			wr(`BOD_IDX_OPSEL, 32'(k));
			wr(`BOD_IDX_ROP, {28'h0, r});
			wr(`BOD_IDX_PATCFG, {31'h0, k[0]});
			wr(`BOD_IDX_SRC, {8'h0, s});
			wr(`BOD_IDX_ACTIVE, 32'h1);
			if (k < 13) begin
				rdc(`BOD_IDX_ACTIVE, 32'h1, "active busy");
				wait_cmd();
				cmp("op", 32'(k), 32'(cmd_desc.op));
				cmp("neg_dir", 32'(k == 3), 32'(cmd_desc.neg_dir));
				cmp("transparent", 32'(k inside {4, 5, 7, 9, 11}), 32'(cmd_desc.transparent));
				cmp("use_pat", 32'(k inside {6, 7}), 32'(cmd_desc.use_pat));
				cmp("cexp", 32'(k inside {8, 9, 10, 11}), 32'(cmd_desc.cexp));
				cmp("use_rop", 32'(k inside {0, 2, 3, 6}), 32'(cmd_desc.use_rop));
				cmp("rop", {28'h0, r}, 32'(cmd_desc.rop));
				if (k inside {8, 9, 10, 11})
					cmp("start_bit", {28'h0, r}, 32'(cmd_desc.start_bit));
				if (k[0]) begin
					cmp("base16", {11'h0, s[20:7], 7'h0}, 32'(cmd_desc.pat_base));
					cmp("line16", 32'(s[6:4]), 32'(cmd_desc.pat_line));
					cmp("pixel16", 32'(s[3:0]), 32'(cmd_desc.pat_pixel));
				end else begin
					cmp("base8", {11'h0, s[20:6], 6'h0}, 32'(cmd_desc.pat_base));
					cmp("line8", 32'(s[5:3]), 32'(cmd_desc.pat_line));
					cmp("pixel8", {28'h0, 1'b0, s[2:0]}, 32'(cmd_desc.pat_pixel));
				end
				cmp("src_addr", {8'h0, s}, 32'(cmd_desc.src_addr));
				rdc(`BOD_IDX_STATUS, 32'(k), "status op");
				take_cmd();
				end_op();
				rdc(`BOD_IDX_ACTIVE, 32'h0, "active idle");
			end else begin
				// Reserved code: start stays idle and pushes nothing; the refusal flag is set and the held descriptor takes BOD_OP_RSVD
				rdc(`BOD_IDX_ACTIVE, 32'h0, "reserved active");
				bus(1'b0, `BOD_IDX_STATUS, 32'h0, d);
				cmp("reserved flag", 32'h1, 32'(d[4]));
				cmp("reserved push", 32'h0, 32'(cmd_valid));
			end
		end
		// Combine unit across all sixteen codes
		for (int k = 0; k < 16; k++) begin
			wr(`BOD_IDX_ROP, 32'(k));
			@(posedge core_clk);
			#1;
			cmp("comb_out", 32'(comb_exp(k[3:0], comb_src, comb_dst)), 32'(comb_out));
			// Named functions written out as boolean expressions of S and D
			e6 = (k == 0) ? 16'h0000 : (k == 1) ? ~(comb_src | comb_dst)
				: (k == 2) ? (~comb_src & comb_dst) : (comb_src & ~comb_dst);
			if (k inside {0, 1, 2, 4})
				cmp("comb_rule", {16'h0, e6}, 32'(comb_out));
		end
		// Fill the command buffer with the datapath stalled, then drain in order
		for (int k = 0; k < 8; k++) begin
			wr(`BOD_IDX_OPSEL, 32'(k));
			wr(`BOD_IDX_ACTIVE, 32'h1);
			rdc(`BOD_IDX_ACTIVE, 32'h1, "fill busy");
			end_op();
		end
		bus(1'b0, `BOD_IDX_STATUS, 32'h0, d);
		cmp("fifo full", 32'h1, 32'(d[5]));
		for (int k = 0; k < 8; k++) begin
			wait_cmd();
			cmp("fifo order", 32'(k), 32'(cmd_desc.op));
			take_cmd();
		end
		@(posedge core_clk);
		#1;
		cmp("fifo empty", 32'h0, 32'(cmd_valid));
		test_done();
	end
endmodule
